// File: design/ctxlp_top.sv
// CAN transmit empty flags, abort side effects, sleep, wake-up and power-down control
`timescale 1ns/100ps
`default_nettype none

module ctxlp_top
    import ctxlp_pkg::*;
#(
    parameter logic [15:0] RECOVERY_CYCLES = RST_RECOVERY_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cpu_stop,
    input  wire logic        cpu_wait,
    input  wire logic        link_idle,
    input  wire logic [2:0]  tx_done,
    input  wire logic [2:0]  abort_done,
    input  wire logic        bit_tick,
    input  wire logic        bus_off,
    input  wire logic        core_tx_bit,
    input  wire logic        bus_receive_pin,
    output logic             bus_transmit_pin,
    output logic             core_rx_bit,
    output logic      [2:0]  tx_schedule,
    output logic      [2:0]  tx_abort_req,
    output logic      [2:0]  tx_buf_lock,
    output logic             tx_irq,
    output logic             link_active,
    output logic             link_halt,
    output logic             busoff_recovered
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    ctxlp_regs_t q;
    ctxlp_regs_t d;

    logic        pwr_down;
    logic        init_mode;
    logic        active;
    logic        wr_en;
    logic        mapped;
    logic [2:0]  sw_clr;
    logic [2:0]  hw_set;
    logic [31:0] rd_val;

    // Power-down request from the processor
    // stop, or wait when stop_in_wait is set
    assign pwr_down  = cpu_stop | (cpu_wait & q.stop_in_wait);
    assign init_mode = q.init_rq & q.init_ak;
    // Normal operation lets pending work run
    assign active    = (q.state == ST_NORMAL) & ~pwr_down & ~init_mode;
    // no register access in power down
    assign wr_en     = ce & psel & penable & pwrite & ~pwr_down;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    // Read mux and unmapped detection
    always_comb begin
        rd_val = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            OFF_TX_FLAGS: rd_val[2:0] = q.flags;
            OFF_TX_IER:   rd_val[2:0] = q.ier;
            OFF_TX_ARQ:   rd_val[2:0] = q.arq;
            OFF_TX_AAK:   rd_val[2:0] = q.aak;
            OFF_CTRL0: begin
                rd_val[CTRL0_INIT_REQUEST]  = q.init_rq;
                rd_val[CTRL0_SLEEP_REQUEST] = q.slp_rq;
                rd_val[CTRL0_WAKEUP_ENABLE] = q.wakeup_enable;
            end
            OFF_CTRL1: begin
                rd_val[CTRL1_LISTEN]       = q.listen;
                rd_val[CTRL1_STOP_IN_WAIT] = q.stop_in_wait;
            end
            OFF_STATUS: begin
                rd_val[STAT_INIT_ACK]   = q.init_ak;
                rd_val[STAT_SLEEP_ACK]  = (q.state == ST_SLEEP);
                rd_val[STAT_WAKE_SYNC]  = (q.state == ST_WAKE_SYNC);
                rd_val[STAT_RECOVERING] = (q.state == ST_RECOVER);
                rd_val[STAT_POWER_DOWN] = (q.state == ST_POWER_DOWN);
            end
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Register writes, flag updates and mode sequencing
    always_comb begin
        d      = q;
        sw_clr = 3'h0;
        hw_set = 3'h0;
        d.busoff_done = 1'b0;

        // Read data captured in the setup cycle
        if (psel & ~penable) begin
            d.prdata = pwr_down ? 32'h0000_0000 : rd_val;
        end

        // Acknowledge follows the init request one cycle later
        d.init_ak = q.init_rq;

        if (wr_en) begin
            unique case (paddr)
                OFF_TX_FLAGS: begin
                    // writable only when both init bits and the listen bit are low
                    if (~q.init_rq & ~q.init_ak & ~q.listen) begin
                        sw_clr = pwdata[2:0];
                    end
                end
                OFF_TX_IER: d.ier = pwdata[2:0];
                // Abort requests only stick on scheduled buffers
                OFF_TX_ARQ: d.arq = q.arq | (pwdata[2:0] & ~q.flags);
                OFF_CTRL0: begin
                    d.init_rq = pwdata[CTRL0_INIT_REQUEST];
                    d.wakeup_enable    = pwdata[CTRL0_WAKEUP_ENABLE];
                    if (pwdata[CTRL0_SLEEP_REQUEST]) begin
                        d.slp_rq = 1'b1;
                    end else if (q.state == ST_SLEEP) begin
                        d.slp_rq = 1'b0;
                    end
                end
                OFF_CTRL1: begin
                    d.listen       = pwdata[CTRL1_LISTEN];
                    d.stop_in_wait = pwdata[CTRL1_STOP_IN_WAIT];
                end
                default: ;
            endcase
        end

        hw_set = (tx_done | abort_done) & ~q.flags & {3{~pwr_down}};
        // set wins over a simultaneous software clear
        d.flags = (q.flags & ~sw_clr) | hw_set;
        d.aak   = (q.aak & ~sw_clr) | (abort_done & hw_set);
        d.arq   = d.arq & ~hw_set;

        if (init_mode) begin
            d.flags = RST_TX_FLAGS;
            d.arq   = 3'h0;
            d.aak   = 3'h0;
        end

        // Mode state machine
        unique case (q.state)
            ST_NORMAL: begin
                if (pwr_down) begin
                    d.state         = ST_POWER_DOWN;
                    d.pd_from_sleep = 1'b0;
                end else if (q.slp_rq & link_idle) begin
                    d.state      = ST_SLEEP;
                    d.wakeup_enable_armed = q.wakeup_enable;
                end
            end
            ST_SLEEP: begin
                if (pwr_down) begin
                    d.state         = ST_POWER_DOWN;
                    d.pd_from_sleep = 1'b1;
                end else if (~q.slp_rq) begin
                    d.state = ST_WAKE_SYNC;
                    d.run   = 4'h0;
                end else if (q.wakeup_enable_armed & ~bus_receive_pin) begin
                    d.state  = ST_WAKE_SYNC;
                    d.slp_rq = 1'b0;
                    d.run    = 4'h0;
                end
            end
            ST_WAKE_SYNC: begin
                if (pwr_down) begin
                    d.state         = ST_POWER_DOWN;
                    d.pd_from_sleep = 1'b0;
                end else if (bit_tick) begin
                    if (~bus_receive_pin) begin
                        d.run = 4'h0;
                    end else if (q.run == WAKE_RECESSIVE_BITS - 4'h1) begin
                        d.run   = 4'h0;
                        d.state = ST_NORMAL;
                    end else begin
                        d.run = q.run + 4'h1;
                    end
                end
            end
            ST_POWER_DOWN: begin
                if (~pwr_down) begin
                    // recovery only when not sleeping before
                    d.state = q.pd_from_sleep ? ST_SLEEP : ST_RECOVER;
                    d.cnt   = 16'h0000;
                end
            end
            ST_RECOVER: begin
                if (pwr_down) begin
                    d.state         = ST_POWER_DOWN;
                    d.pd_from_sleep = 1'b0;
                end else if (q.cnt >= RECOVERY_CYCLES - 16'h0001) begin
                    d.state = ST_NORMAL;
                    d.cnt   = 16'h0000;
                end else begin
                    d.cnt = q.cnt + 16'h0001;
                end
            end
            default: d.state = ST_NORMAL;
        endcase

        // ------------------------------------------------------------
        // Bus-off recovery counting
        // ------------------------------------------------------------
        // The run counter is shared with the wake-up sync, which only
        // uses it outside normal mode, so the two never collide.
        // The occurrence count is kept across sleep and power down.
        // bus-off run counting, held outside normal mode
        if (active & bus_off & bit_tick) begin
            if (~bus_receive_pin) begin
                // Dominant bit restarts the recessive run
                d.run = 4'h0;
            end else if (q.run == WAKE_RECESSIVE_BITS - 4'h1) begin
                // One full run of recessive bits seen
                d.run = 4'h0;
                if (q.occ == BUSOFF_OCCURRENCES - 8'h01) begin
                    d.occ         = 8'h00;
                    d.busoff_done = 1'b1;
                end else begin
                    d.occ = q.occ + 8'h01;
                end
            end else begin
                d.run = q.run + 4'h1;
            end
        end else if (~bus_off) begin
            // Count restarts with the next bus-off episode
            d.occ = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Whole record in one register; clock enable freezes it all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q       <= '0;
            q.flags <= RST_TX_FLAGS;
            q.ier   <= RST_TX_IER;
        end else if (ce) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Register bus answer
    // ------------------------------------------------------------
    // Read data registered in the setup cycle
    assign prdata  = q.prdata;
    assign pready  = ~pwr_down;
    // Unmapped offsets answer with an error
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------
    // listen mode starts no transmission
    assign tx_schedule  = ~q.flags & {3{active & ~q.listen}};
    assign tx_abort_req = q.arq & {3{active}};
    assign tx_buf_lock  = tx_schedule;
    assign tx_irq       = |(q.flags & q.ier);

    // ------------------------------------------------------------
    // Pins and link control
    // ------------------------------------------------------------
    // recessive pin unless in normal operation
    // The pin follows the power-down request at once, so a frame
    // that is cut off leaves the bus recessive, not stuck dominant.
    assign bus_transmit_pin = active ? core_tx_bit : 1'b1;
    // receive held recessive in sleep when wake-up not armed
    assign core_rx_bit      = ((q.state == ST_SLEEP) & ~q.wakeup_enable_armed) ? 1'b1
                                                                      : bus_receive_pin;
    // Protocol engine may run only in normal mode
    assign link_active      = (q.state == ST_NORMAL) & ~pwr_down;
    assign link_halt        = pwr_down | (q.state == ST_POWER_DOWN);
    // one-cycle pulse after the last recessive run
    assign busoff_recovered = q.busoff_done;

endmodule
`default_nettype wire

// File: inc/ctxlp_pkg.sv
// Constants, state encoding and state record of the CAN transmit flag and low-power block
package ctxlp_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_TX_BUF = 3;

    // ------------------------------------------------------------
    // Register byte offsets on the APB
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_TX_FLAGS = 8'h00;  // tx_buffer_empty_flags
    localparam logic [7:0] OFF_TX_IER   = 8'h04;  // tx_interrupt_enable_reg
    localparam logic [7:0] OFF_TX_ARQ   = 8'h08;  // tx_abort_request_reg
    localparam logic [7:0] OFF_TX_AAK   = 8'h0C;  // tx_abort_acknowledge_reg
    localparam logic [7:0] OFF_CTRL0    = 8'h10;  // control_reg_0
    localparam logic [7:0] OFF_CTRL1    = 8'h14;  // control_reg_1
    localparam logic [7:0] OFF_STATUS   = 8'h18;  // mode status, read only

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL0_INIT_REQUEST  = 0;
    localparam int unsigned CTRL0_SLEEP_REQUEST = 1;
    localparam int unsigned CTRL0_WAKEUP_ENABLE = 2;
    localparam int unsigned CTRL1_LISTEN        = 0;
    localparam int unsigned CTRL1_STOP_IN_WAIT  = 1;
    localparam int unsigned STAT_INIT_ACK       = 0;
    localparam int unsigned STAT_SLEEP_ACK      = 1;
    localparam int unsigned STAT_WAKE_SYNC      = 2;
    localparam int unsigned STAT_RECOVERING     = 3;
    localparam int unsigned STAT_POWER_DOWN     = 4;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [2:0]  RST_TX_FLAGS        = 3'h7;
    localparam logic [2:0]  RST_TX_IER          = 3'h0;
    localparam logic [3:0]  WAKE_RECESSIVE_BITS = 4'hB;   // 11 bits
    localparam logic [7:0]  BUSOFF_OCCURRENCES  = 8'h80;  // 128 runs
    localparam logic [15:0] RST_RECOVERY_CYCLES = 16'h0040;

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_NORMAL     = 3'b000,
        ST_SLEEP      = 3'b001,
        ST_WAKE_SYNC  = 3'b010,
        ST_POWER_DOWN = 3'b011,
        ST_RECOVER    = 3'b100
    } ctxlp_state_t;

    typedef struct packed {
        logic [2:0]   flags;
        logic [2:0]   ier;
        logic [2:0]   arq;
        logic [2:0]   aak;
        logic         init_rq;
        logic         init_ak;
        logic         slp_rq;
        logic         wakeup_enable;
        logic         wakeup_enable_armed;
        logic         listen;
        logic         stop_in_wait;
        logic         pd_from_sleep;
        ctxlp_state_t state;
        logic [15:0]  cnt;
        logic [3:0]   run;
        logic [7:0]   occ;
        logic         busoff_done;
        logic [31:0]  prdata;
    } ctxlp_regs_t;

endpackage

// File: tb/ctxlp_bus_node.sv
// Model of the other nodes on the CAN bus
`timescale 1ns/100ps
`default_nettype none
module ctxlp_bus_node (
    input  wire logic pclk,
    input  wire logic bus_transmit_pin,
    input  wire logic activity,
    output logic      bus_receive_pin,
    output logic      bit_tick
);
    logic [1:0] div_q = 2'h0;
    logic       dom_q = 1'b0;
    // Bit time of four clocks, dominant bits alternate while active
    always @(posedge pclk) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3) begin
            dom_q <= activity && !dom_q;
        end
    end
    assign bit_tick = (div_q == 2'h3);
    assign bus_receive_pin = bus_transmit_pin && !dom_q;
endmodule
`default_nettype wire

// File: tb/ctxlp_monitor.sv
// Port assertions for the transmit flag and low-power block
`timescale 1ns/100ps
`default_nettype none
module ctxlp_monitor
    import ctxlp_pkg::*;
#(
    parameter logic [15:0] RECOVERY_CYCLES = RST_RECOVERY_CYCLES
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       pready,
    input wire logic       cpu_stop,
    input wire logic       cpu_wait,
    input wire logic [2:0] tx_done,
    input wire logic [2:0] abort_done,
    input wire logic       bus_transmit_pin,
    input wire logic [2:0] tx_schedule,
    input wire logic [2:0] tx_abort_req,
    input wire logic [2:0] tx_buf_lock,
    input wire logic       link_active,
    input wire logic       link_halt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_pd_recessive: assert property (
        cpu_stop && $past(cpu_stop) |-> bus_transmit_pin) else $error("pin driven in stop");
    chk_pd_halt: assert property (
        $rose(cpu_stop) |-> ##[0:2] link_halt) else $error("no halt on stop");
    chk_pd_silent: assert property (
        cpu_stop && $past(cpu_stop) |-> !pready) else $error("answer in stop");
    chk_done_empty: assert property (
        tx_done[0] && tx_schedule[0] |-> ##[1:2] !tx_schedule[0]) else $error("done kept");
    chk_abort_clear: assert property (
        abort_done[1] && tx_abort_req[1] |-> ##[1:2] !tx_abort_req[1] && !tx_schedule[1])
        else $error("abort kept");
    chk_sched_lock: assert property (
        tx_schedule[0] && $past(tx_schedule[0]) |-> tx_buf_lock[0]) else $error("not locked");
    chk_recov_hold: assert property (
        $fell(cpu_stop) && !cpu_wait |=> !link_active [*6]) else $error("recovery short");
    chk_recov_end: assert property (
        $fell(cpu_stop) && !cpu_wait |-> ##[1:300] link_active) else $error("no recovery");
    // Main scenarios reached
    cover property (tx_done[0] && tx_schedule[0]);
    cover property (abort_done[1] && tx_abort_req[1]);
    cover property ($fell(cpu_stop));
endmodule
bind ctxlp_top ctxlp_monitor #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_mon (.pclk, .presetn,
    .pready, .cpu_stop, .cpu_wait, .tx_done, .abort_done, .bus_transmit_pin, .tx_schedule,
    .tx_abort_req, .tx_buf_lock, .link_active, .link_halt);
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the transmit flag and low-power block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_top
    import ctxlp_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, cpu_stop = 1'b0, cpu_wait = 1'b0, core_tx_bit = 1'b1;
    logic [2:0] tx_done = 3'h0, abort_done = 3'h0, tx_schedule, tx_abort_req, tx_buf_lock;
    logic bus_receive_pin, bus_transmit_pin, core_rx_bit, tx_irq, bit_tick, activity = 1'b0;
    logic link_active, link_halt, busoff_recovered;
    int mismatches = 0, comparisons = 0;
    // Clock and units
    always #2.5 pclk = ~pclk;
    ctxlp_top #(.RECOVERY_CYCLES(16'h0008)) dut (.pclk, .presetn, .ce(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_stop, .cpu_wait,
        .link_idle(1'b1), .tx_done, .abort_done, .bit_tick, .bus_off(1'b0), .core_tx_bit,
        .bus_receive_pin, .bus_transmit_pin, .core_rx_bit, .tx_schedule, .tx_abort_req,
        .tx_buf_lock, .tx_irq, .link_active, .link_halt, .busoff_recovered);
    ctxlp_bus_node node (.pclk, .bus_transmit_pin, .activity, .bus_receive_pin, .bit_tick);
    // One APB transfer, read data left in rv
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rv = prdata;
        if (pready !== 1'b1) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, OFF_STATUS, 32'h0);
            n++;
        end while (rv[b] !== v && n < 200);
        `CHK("status", v, rv[b])
    endtask
    task automatic pulse(input logic [2:0] t, input logic [2:0] ab);
        tx_done <= t;
        abort_done <= ab;
        @(posedge pclk);
        tx_done <= 3'h0;
        abort_done <= 3'h0;
        @(posedge pclk);
    endtask
    task automatic wait_up;
        int n;
        n = 0;
        @(negedge pclk);
        while (link_active !== 1'b1 && n < 300) begin
            @(negedge pclk);
            n++;
        end
        `CHK("link_up", 1'b1, link_active)
        @(posedge pclk);
    endtask
    task automatic t_flags;
        apb(1'b1, OFF_CTRL0, 32'h0);
        poll(STAT_INIT_ACK, 1'b0);
        apb(1'b0, OFF_TX_FLAGS, 32'h0);
        `CHK("flags_rst", RST_TX_FLAGS, rv[2:0])
        @(negedge pclk);
        `CHK("irq_off", 1'b0, tx_irq)
        @(posedge pclk);
        apb(1'b1, OFF_TX_IER, 32'h7);
        apb(1'b1, OFF_TX_FLAGS, 32'h1); // buffer 0 handed over
        apb(1'b1, OFF_TX_FLAGS, 32'h0);
        apb(1'b0, OFF_TX_FLAGS, 32'h0);
        `CHK("w1c", 3'h6, rv[2:0])
        @(negedge pclk);
        `CHK("sched", 3'h1, tx_schedule)
        `CHK("irq", 1'b1, tx_irq)
        @(posedge pclk);
    endtask
    task automatic t_txab;
        pulse(3'h1, 3'h0);
        apb(1'b0, OFF_TX_FLAGS, 32'h0);
        `CHK("sent", 3'h7, rv[2:0])
        apb(1'b1, OFF_TX_FLAGS, 32'h2);
        apb(1'b1, OFF_TX_ARQ, 32'h2);
        @(negedge pclk);
        `CHK("abort_req", 3'h2, tx_abort_req)
        @(posedge pclk);
        pulse(3'h0, 3'h2);
        apb(1'b0, OFF_TX_FLAGS, 32'h0);
        `CHK("aborted", 3'h7, rv[2:0])
        apb(1'b0, OFF_TX_ARQ, 32'h0);
        `CHK("arq_clr", 3'h0, rv[2:0])
        apb(1'b0, OFF_TX_AAK, 32'h0);
        `CHK("aak_set", 3'h2, rv[2:0])
        apb(1'b1, OFF_TX_FLAGS, 32'h2);
        apb(1'b0, OFF_TX_AAK, 32'h0);
        `CHK("aak_clr", 3'h0, rv[2:0])
    endtask
    task automatic t_modes;
        apb(1'b1, OFF_CTRL1, 32'h1 << CTRL1_LISTEN);
        apb(1'b1, OFF_TX_FLAGS, 32'h4);
        apb(1'b0, OFF_TX_FLAGS, 32'h0);
        `CHK("listen", 3'h5, rv[2:0])
        @(negedge pclk);
        `CHK("no_sched", 3'h0, tx_schedule)
        @(posedge pclk);
        apb(1'b1, OFF_CTRL1, 32'h0);
        apb(1'b1, OFF_CTRL0, 32'h1 << CTRL0_INIT_REQUEST);
        poll(STAT_INIT_ACK, 1'b1);
        apb(1'b1, OFF_TX_FLAGS, 32'h1);
        apb(1'b0, OFF_TX_FLAGS, 32'h0);
        `CHK("init_hold", RST_TX_FLAGS, rv[2:0])
        apb(1'b1, OFF_CTRL0, 32'h0);
        poll(STAT_INIT_ACK, 1'b0);
    endtask
    task automatic t_sleep;
        apb(1'b1, OFF_CTRL0, 32'h1 << CTRL0_SLEEP_REQUEST);
        poll(STAT_SLEEP_ACK, 1'b1);
        activity <= 1'b1;
        repeat (10) begin
            repeat (4) @(posedge pclk);
            @(negedge pclk);
            `CHK("rx_masked", 1'b1, core_rx_bit)
        end
        @(posedge pclk);
        activity <= 1'b0;
        poll(STAT_SLEEP_ACK, 1'b1);
        apb(1'b1, OFF_CTRL0, 32'h0); // cleared only once asleep
        poll(STAT_SLEEP_ACK, 1'b0);
        poll(STAT_WAKE_SYNC, 1'b0);
        apb(1'b1, OFF_CTRL0, 32'h6);
        poll(STAT_SLEEP_ACK, 1'b1);
        activity <= 1'b1;
        poll(STAT_SLEEP_ACK, 1'b0);
        activity <= 1'b0;
        poll(STAT_WAKE_SYNC, 1'b0);
        apb(1'b1, OFF_CTRL0, 32'h0);
    endtask
    // stop from normal mode on purpose, to reach the recovery path
    task automatic t_pd;
        core_tx_bit <= 1'b0;
        cpu_stop <= 1'b1;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        `CHK("pin_rec", 1'b1, bus_transmit_pin)
        `CHK("halt", 1'b1, link_halt)
        @(posedge pclk);
        cpu_stop <= 1'b0;
        core_tx_bit <= 1'b1;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        `CHK("recover", 1'b0, link_active)
        @(posedge pclk);
        wait_up;
        apb(1'b1, OFF_CTRL1, 32'h1 << CTRL1_STOP_IN_WAIT);
        cpu_wait <= 1'b1;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        `CHK("wait_halt", 1'b1, link_halt)
        @(posedge pclk);
        cpu_wait <= 1'b0;
        wait_up;
    endtask
    task automatic finish_test;
        if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_flags;
        t_txab;
        t_modes;
        t_sleep;
        t_pd;
        finish_test;
    end
    // Watchdog against hangs
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        finish_test;
    end
endmodule
`default_nettype wire
